// ==== core/coprocessor_host_config.sv ====
// coprocessor_host_config: register bank, coherent pair controller, stop control, input filters
//
// The address map and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - start bit one launches two-parameter transfer
// - host waits until done; start reads zero
// - target word is {transfer base, index}
// - buffer word is buffer base times two
// - width bit keeps or replaces upper byte
// - direction bit picks copy source and destination
// - expected signature register compared at cycle end
// - force end pulses engine reset, waits host
// - force end ignored in test, halt, idle
// - stop gates clocks, time bases, sampling
// - channel accesses error once stop set
// - stopped flag rises on next clock edge
// - stop bit locked while code visible
// - stopped flag; shared stop acknowledged jointly
// - halted flag follows microengine halt state
// - prescale code sets divide two to 256
// - mode 00 needs two agreeing samples
// - entry base field selects entry table
// - time base writes error in stop
// - entry addresses are base times 0x800, 0x200
// - mode 10 needs three agreeing samples
// - mode 11 needs all half-rate samples agreeing
module coprocessor_host_config #(
  parameter int NCH = 32
) (
  // clock and reset
  input  wire logic                    mclk_i,
  input  wire logic                    rst_i,
  // ahb-lite slave
  input  wire cphc_pkg::ahb_req_t      ahb_i,
  output      cphc_pkg::ahb_rsp_t      ahb_o,
  // engine parameter ram port
  input  wire cphc_pkg::eng_ram_req_t  eng_ram_i,
  output logic                         eng_gnt_o,
  output logic [31:0]                  eng_rdata_o,
  // engine status and control
  input  wire cphc_pkg::engine_status_t eng_i,
  output logic                         force_end_o,
  output logic                         clk_run_o,
  output logic                         bus_stop_ack_o,
  output logic [15:0]                  entry_host_addr_o,
  output logic [13:0]                  entry_word_addr_o,
  // time base values for host reads
  input  wire logic [23:0]             time_base_one_i,
  input  wire logic [23:0]             time_base_two_i,
  // signature check
  input  wire logic [31:0]             sig_calc_i,
  input  wire logic                    sig_done_i,
  output logic                         sig_mismatch_o,
  // channel inputs
  input  wire logic [NCH-1:0]          chan_pin_i,
  output logic [NCH-1:0]               chan_state_o
);
  import cphc_pkg::*;

  initial begin
    if (NCH < 1 || NCH > 32) $error("NCH must be 1 to 32");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    bus_state_t  st;
    logic        dp_valid;
    logic [15:0] addr;
    logic        wr;
    logic [31:0] rdata;
    logic [31:0] coh;
    logic [31:0] sig;
    logic        stop;
    logic        stopped;
    logic [2:0]  fps;
    logic [1:0]  fmode;
    logic [4:0]  entry_table_base;
    logic        mism;
    logic [31:0] eng_rd;
    logic [7:0]  pre_cnt;
    logic        half;
    logic [NCH-1:0] s1, s2, s3, lvl, smp1, smp2, cand, bad, state;
  } state_t;

  state_t q, d;
  logic [31:0] ram [0:(1<<RAM_AW)-1];

  // ---------------------------------------------------------------
  // decode of the pending data phase
  // ---------------------------------------------------------------
  logic              dp, is_ram, is_chan, is_tb, bad_acc, acc;
  logic [RAM_AW-1:0] tgt0, tgt1, buf0, buf1, src, dst;
  logic [31:0]       mv;
  logic              m_we;
  logic [RAM_AW-1:0] m_addr;
  logic [31:0]       m_data;
  logic              force_thread_end_ok, f_tick, h_tick;
  logic [7:0]        f_mask;

  // data phase decode; address is taken when the previous transfer finishes
  always_comb begin
    dp      = q.dp_valid && (q.st == S_IDLE);
    is_ram  = q.addr[RAM_SEL_BIT];
    is_chan = !q.addr[RAM_SEL_BIT] && (q.addr[14:11] == CHAN_REGION);
    is_tb   = (q.addr == OFF_TB_ONE) || (q.addr == OFF_TB_TWO);
    bad_acc = dp && q.stop && (is_chan || (is_tb && q.wr));
    acc     = ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready;
    force_thread_end_ok = !(eng_i.test_state || eng_i.halt_state || eng_i.idle_state);
  end

  // coherent transfer addressing
  always_comb begin
    tgt0 = {q.coh[CT_BASE_H:CT_BASE_L], q.coh[CT_P0_H:CT_P0_L]};
    tgt1 = {q.coh[CT_BASE_H:CT_BASE_L], q.coh[CT_P1_H:CT_P1_L]};
    buf0 = {1'b0, q.coh[CT_PB_H:CT_PB_L], 1'b0};
    buf1 = {1'b0, q.coh[CT_PB_H:CT_PB_L], 1'b1};
    if (q.coh[CT_DIR]) begin
      src = (q.st == S_XFER0) ? buf0 : buf1;
      dst = (q.st == S_XFER0) ? tgt0 : tgt1;
    end else begin
      src = (q.st == S_XFER0) ? tgt0 : tgt1;
      dst = (q.st == S_XFER0) ? buf0 : buf1;
    end
    mv = ram[src];
    if (!q.coh[CT_WIDTH]) mv[31:24] = ram[dst][31:24];
  end

  // single write port: transfer, then host, then engine
  always_comb begin
    m_we      = 1'b0;
    m_addr    = eng_ram_i.addr;
    m_data    = eng_ram_i.wdata;
    eng_gnt_o = 1'b0;
    if (q.st == S_XFER0 || q.st == S_XFER1) begin
      m_we   = 1'b1;
      m_addr = dst;
      m_data = mv;
    end else if (dp && q.wr && is_ram) begin
      m_we   = 1'b1;
      m_addr = q.addr[RAM_AW+1:2];
      m_data = ahb_i.hwdata;
    end else if (q.st == S_IDLE) begin
      eng_gnt_o = eng_ram_i.req;
      m_we      = eng_ram_i.req && eng_ram_i.we;
    end
  end

  // filter clock prescaler and half-rate tick
  always_comb begin
    f_mask = 8'((9'h002 << q.fps) - 9'h001);
    f_tick = !q.stopped && ((q.pre_cnt & f_mask) == f_mask);
    h_tick = !q.stopped && q.half;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.mism = 1'b0;
    // address phase
    if (acc) begin
      d.dp_valid = 1'b1;
      d.addr     = {ahb_i.haddr[15:2], 2'b00};
      d.wr       = ahb_i.hwrite;
      d.rdata    = RST_ZERO;
      if (ahb_i.haddr[RAM_SEL_BIT]) d.rdata = ram[ahb_i.haddr[RAM_AW+1:2]];
      else begin
        case ({ahb_i.haddr[15:2], 2'b00})
          OFF_COHERENT:  d.rdata = q.coh;
          OFF_SIGNATURE: d.rdata = q.sig;
          OFF_ENGINE: begin
            d.rdata[EC_STOP]             = q.stop;
            d.rdata[EC_STF]              = q.stopped;
            d.rdata[EC_HALTED_FLAG]             = eng_i.halt_state;
            d.rdata[EC_FPS_H:EC_FPS_L]   = q.fps;
            d.rdata[EC_FM_H:EC_FM_L]     = q.fmode;
            d.rdata[EC_ETB_H:EC_ETB_L]   = q.entry_table_base;
          end
          OFF_TB_ONE: d.rdata = {8'h00, time_base_one_i};
          OFF_TB_TWO: d.rdata = {8'h00, time_base_two_i};
          default:    d.rdata = RST_ZERO;
        endcase
      end
    end else if (!dp || bad_acc) begin
      d.dp_valid = (q.st != S_IDLE) ? q.dp_valid : 1'b0;
    end else begin
      d.dp_valid = 1'b0;
    end
    // data phase and waits
    case (q.st)
      S_IDLE: begin
        if (bad_acc) begin
          d.st = S_ERR2;
        end else if (dp && q.wr && !is_ram) begin
          case (q.addr)
            OFF_COHERENT: begin
              d.coh = ahb_i.hwdata & CT_WMASK;
              if (ahb_i.hwdata[CT_START]) d.st = S_XFER0;
            end
            OFF_SIGNATURE: d.sig = ahb_i.hwdata;
            OFF_ENGINE: begin
              if (!eng_i.code_vis) d.stop = ahb_i.hwdata[EC_STOP];
              d.fps   = ahb_i.hwdata[EC_FPS_H:EC_FPS_L];
              d.fmode = ahb_i.hwdata[EC_FM_H:EC_FM_L];
              d.entry_table_base   = ahb_i.hwdata[EC_ETB_H:EC_ETB_L];
              if (ahb_i.hwdata[EC_FORCE_THREAD_END] && force_thread_end_ok) d.st = S_FORCE_THREAD_END;
            end
            default: d.st = S_IDLE;
          endcase
        end
      end
      S_XFER0: d.st = S_XFER1;
      S_XFER1: d.st = S_IDLE;
      S_FORCE_THREAD_END:  d.st = S_IDLE;
      S_ERR2:  d.st = S_IDLE;
      default: d.st = S_IDLE;
    endcase
    // engine ram read data
    if (eng_gnt_o && !eng_ram_i.we) d.eng_rd = ram[eng_ram_i.addr];
    // stop completes one edge after the condition holds
    d.stopped = (q.stop || eng_i.bus_stop) && !eng_i.thread_busy;
    // signature compare at end of cycle
    d.mism = sig_done_i && (sig_calc_i != q.sig);
    // prescaler frozen while stopped
    if (!q.stopped) begin
      d.pre_cnt = q.pre_cnt + 8'h01;
      d.half    = !q.half;
    end
    // per-channel input synchroniser and filter
    for (int i = 0; i < NCH; i++) begin
      d.s1[i] = chan_pin_i[i];
      d.s2[i] = q.s1[i];
      d.s3[i] = q.s2[i];
      if (q.s2[i] == q.s3[i]) d.lvl[i] = q.s3[i];
      if (h_tick && (q.lvl[i] != q.cand[i])) d.bad[i] = 1'b1;
      if (f_tick) begin
        d.smp1[i] = q.lvl[i];
        d.smp2[i] = q.smp1[i];
        d.cand[i] = q.lvl[i];
        d.bad[i]  = 1'b0;
        case (q.fmode)
          FM_THREE: begin
            if (q.lvl[i] == q.smp1[i] && q.smp1[i] == q.smp2[i])
              d.state[i] = q.lvl[i];
          end
          FM_CONT: begin
            if (!q.bad[i] && q.lvl[i] == q.cand[i])
              d.state[i] = q.cand[i];
          end
          default: begin
            if (q.lvl[i] == q.smp1[i]) d.state[i] = q.lvl[i];
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      q <= '0;          // filter mode 00 after reset
    end else begin
      q <= d;
    end
  end

  // parameter ram write port
  always_ff @(posedge mclk_i) begin
    if (m_we) ram[m_addr] <= m_data;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_comb begin
    ahb_o.hrdata    = q.rdata;
    ahb_o.hresp     = bad_acc || (q.st == S_ERR2);
    ahb_o.hreadyout = (q.st == S_ERR2) || (q.st == S_XFER1) ||
                      ((q.st == S_IDLE) && !bad_acc &&
                       !(dp && q.wr && !is_ram && (q.addr == OFF_COHERENT) &&
                         ahb_i.hwdata[CT_START]) &&
                       !(dp && q.wr && !is_ram && (q.addr == OFF_ENGINE) &&
                         ahb_i.hwdata[EC_FORCE_THREAD_END] && force_thread_end_ok));
    force_end_o       = (q.st == S_FORCE_THREAD_END);
    clk_run_o         = !q.stopped;
    bus_stop_ack_o    = eng_i.bus_stop && q.stopped && eng_i.peer_stopped;
    entry_host_addr_o = 16'({11'h000, q.entry_table_base} << ETB_HOST_SHIFT);
    entry_word_addr_o = 14'({9'h000, q.entry_table_base} << ETB_WORD_SHIFT);
    sig_mismatch_o    = q.mism;
    eng_rdata_o       = q.eng_rd;
    chan_state_o      = q.state;
  end
endmodule : coprocessor_host_config

`default_nettype wire

// ==== core/cphc_pkg.sv ====
// package: register map, field positions, states and carriers of the host configuration block
package cphc_pkg;
  // ---------------------------------------------------------------
  // register map (byte offsets)
  // ---------------------------------------------------------------
  localparam logic [15:0] OFF_COHERENT  = 16'h0000;
  localparam logic [15:0] OFF_SIGNATURE = 16'h0004;
  localparam logic [15:0] OFF_ENGINE    = 16'h0008;
  localparam logic [15:0] OFF_TB_ONE    = 16'h0040;
  localparam logic [15:0] OFF_TB_TWO    = 16'h0044;
  localparam int          RAM_SEL_BIT   = 14;       // haddr[14]=1: parameter ram window
  localparam logic [3:0]  CHAN_REGION   = 4'h1;     // haddr[14:11]: channel registers
  localparam int          RAM_AW        = 12;       // word index {base, index}
  // ---------------------------------------------------------------
  // coherent_transfer_control fields
  // ---------------------------------------------------------------
  localparam int CT_START  = 31;
  localparam int CT_BASE_H = 30;
  localparam int CT_BASE_L = 26;
  localparam int CT_PB_H   = 25;
  localparam int CT_PB_L   = 16;
  localparam int CT_WIDTH  = 15;
  localparam int CT_P0_H   = 14;
  localparam int CT_P0_L   = 8;
  localparam int CT_DIR    = 7;
  localparam int CT_P1_H   = 6;
  localparam int CT_P1_L   = 0;
  localparam logic [31:0] CT_WMASK = 32'h7fffffff;  // start bit never stored
  // ---------------------------------------------------------------
  // engine_configuration fields
  // ---------------------------------------------------------------
  localparam int EC_FORCE_THREAD_END   = 31;
  localparam int EC_STOP   = 30;
  localparam int EC_STF    = 28;
  localparam int EC_HALTED_FLAG   = 23;
  localparam int EC_FPS_H  = 18;
  localparam int EC_FPS_L  = 16;
  localparam int EC_FM_H   = 15;
  localparam int EC_FM_L   = 14;
  localparam int EC_ETB_H  = 4;
  localparam int EC_ETB_L  = 0;
  localparam int ETB_HOST_SHIFT = 11;  // times 0x800
  localparam int ETB_WORD_SHIFT = 9;   // times 0x200
  localparam logic [31:0] RST_ZERO = 32'h00000000;
  // ---------------------------------------------------------------
  // filter modes and ahb codes
  // ---------------------------------------------------------------
  localparam logic [1:0] FM_TWO   = 2'b00;
  localparam logic [1:0] FM_THREE = 2'b10;
  localparam logic [1:0] FM_CONT  = 2'b11;
  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'b10;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_XFER0 = 3'b001,
    S_XFER1 = 3'b010,
    S_FORCE_THREAD_END  = 3'b011,
    S_ERR2  = 3'b100
  } bus_state_t;

  typedef struct packed {
    logic        hsel;
    logic [15:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } ahb_req_t;

  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } ahb_rsp_t;

  typedef struct packed {
    logic              req;
    logic              we;
    logic [RAM_AW-1:0] addr;
    logic [31:0]       wdata;
  } eng_ram_req_t;

  typedef struct packed {
    logic        test_state;
    logic        halt_state;
    logic        idle_state;
    logic        thread_busy;
    logic        bus_stop;
    logic        peer_stopped;
    logic        code_vis;
  } engine_status_t;
endpackage : cphc_pkg

// ==== dv/coprocessor_host_config_tb.sv ====
// self-checking bench of the host configuration block
`timescale 1ns/10ps
`default_nettype none
module coprocessor_host_config_tb;
  import cphc_pkg::*;
  ahb_req_t       m = '0;
  ahb_req_t       ai;
  ahb_rsp_t       ao;
  eng_ram_req_t   er;
  engine_status_t st = '0;
  logic           mclk_i = 1'b0;
  logic           rst_i = 1'b1;
  logic           gnt, fe, run, ack, mis, ev;
  logic           sd = 1'b0;
  logic [31:0]    sc = '0;
  logic [31:0]    erd, rv, d;
  logic [15:0]    eh;
  logic [13:0]    ew;
  logic [23:0]    t1, t2;
  logic [3:0]     pin = '0;
  logic [3:0]     cs;
  logic [4:0]     cb;
  logic [9:0]     pb;
  logic [11:0]    ta [2] = '{12'h0, 12'h0};
  logic [31:0]    bw [2];
  logic [31:0]    tw [2];
  int             errors = 0;
  int             checked = 0;
  int             fc = 0;
  int             n;
  coprocessor_host_config #(.NCH(4)) dut_u (
    .mclk_i(mclk_i), .rst_i(rst_i), .ahb_i(ai), .ahb_o(ao), .eng_ram_i(er),
    .eng_gnt_o(gnt), .eng_rdata_o(erd), .eng_i(st), .force_end_o(fe),
    .clk_run_o(run), .bus_stop_ack_o(ack), .entry_host_addr_o(eh),
    .entry_word_addr_o(ew), .time_base_one_i(t1), .time_base_two_i(t2),
    .sig_calc_i(sc), .sig_done_i(sd), .sig_mismatch_o(mis),
    .chan_pin_i(pin), .chan_state_o(cs));
  cphc_engine_model eng_u (
    .mclk_i(mclk_i), .rst_i(rst_i), .clk_run_i(run), .gnt_i(gnt),
    .rd_addr_i(ta[0]), .ram_o(er), .tb1_o(t1), .tb2_o(t2));
  always #4 mclk_i = ~mclk_i;
  // ready fed back as the bus hready
  always_comb begin
    ai = m;
    ai.hready = ao.hreadyout;
  end
  always @(posedge mclk_i) if (fe === 1'b1) fc++;
  function automatic logic [15:0] ram_a(input logic [11:0] w);
    return {2'b01, w, 2'b00};
  endfunction : ram_a
  // destination after a move: narrow moves keep the upper byte
  function automatic logic [31:0] mv(input logic w, input logic [31:0] s, input logic [31:0] o);
    return w ? s : {o[31:24], s[23:0]};
  endfunction : mv
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask : chk
  // waits for ready in the settled cycle, takes data, then passes the sampling edge
  task automatic rdy;
    n = 0;
    #1;
    while (ao.hreadyout !== 1'b1 && n < 50) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    if (n >= 50) errors++;
    rv = ao.hrdata;
    ev = ao.hresp;
    @(posedge mclk_i);
  endtask : rdy
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] v);
    m.hsel <= 1'b1;
    m.haddr <= a;
    m.hwrite <= w;
    m.htrans <= HTRANS_NONSEQ_BIT;
    m.hsize <= 3'b010;
    rdy();
    m.hsel <= 1'b0;
    m.htrans <= 2'b00;
    m.hwdata <= v;
    rdy();
  endtask : bus
  task automatic conclude;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  initial begin
    #400000;
    errors++;
    conclude();
  end
  initial begin
    d = $urandom(96528);
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 16'(i * 4), '0);
      chk("reset or hole", RST_ZERO, rv);
      chk("hole response", 32'h0, {31'h0, ev});
    end
    d = $urandom;
    bus(1'b1, OFF_SIGNATURE, d);
    bus(1'b0, OFF_SIGNATURE, '0);
    chk("signature", d, rv);
    for (int j = 0; j < 2; j++) begin
      sc <= d ^ 32'(j);
      sd <= 1'b1;
      @(posedge mclk_i);
      sd <= 1'b0;
      #1;
      chk("mismatch", 32'(j), {31'h0, mis});
      @(posedge mclk_i);
    end
    // every prescale code, the three filter modes, random other fields
    for (int i = 0; i < 8; i++) begin
      d = $urandom & 32'h3fffffff;
      d[18:16] = 3'(i);
      d[15:14] = (i % 3 == 0) ? FM_TWO : (i % 3 == 1) ? FM_THREE : FM_CONT;
      bus(1'b1, OFF_ENGINE, d);
      bus(1'b0, OFF_ENGINE, '0);
      chk("config", d & 32'h0007c01f, rv);
      chk("entry host", {16'h0, d[4:0], 11'h000}, {16'h0, eh});
      chk("entry word", {18'h0, d[4:0], 9'h000}, {18'h0, ew});
      pin[0] <= ~pin[0];
      n = 0;
      #1;
      while (cs[0] !== pin[0] && n < (20 << i)) begin
        @(posedge mclk_i);
        #1;
        n++;
      end
      chk("filter", {31'h0, pin[0]}, {31'h0, cs[0]});
      chk("filter early", 32'h1, {31'h0, n >= (1 << i)});
      @(posedge mclk_i);
    end
    for (int k = 0; k < 3; k++) begin
      cb = 5'h10 | 5'($urandom);
      pb = 10'($urandom);
      ta[0] = {cb, 7'($urandom)};
      ta[1] = {cb, ta[0][6:0] + 7'd1 + 7'($urandom % 126)};
      for (int j = 0; j < 2; j++) begin
        bw[j] = $urandom;
        tw[j] = $urandom;
        bus(1'b1, ram_a({1'b0, pb, 1'b0} + 12'(j)), bw[j]);
        bus(1'b1, ram_a(ta[j]), tw[j]);
      end
      d = {1'b1, cb, pb, k == 0, ta[0][6:0], k < 2, ta[1][6:0]};
      bus(1'b1, OFF_COHERENT, d);
      bus(1'b0, OFF_COHERENT, '0);
      chk("start reads zero", d & CT_WMASK, rv);
      for (int j = 0; j < 2; j++) begin
        bus(1'b0, ram_a(ta[j]), '0);
        chk("target", k < 2 ? mv(k == 0, bw[j], tw[j]) : tw[j], rv);
        bus(1'b0, ram_a({1'b0, pb, 1'b0} + 12'(j)), '0);
        chk("buffer", k < 2 ? bw[j] : mv(k == 0, tw[j], bw[j]), rv);
      end
      chk("engine read", k < 2 ? mv(k == 0, bw[0], tw[0]) : tw[0], erd);
    end
    bus(1'b1, OFF_COHERENT, d & CT_WMASK);
    for (int k = 0; k < 4; k++) begin
      st.test_state <= (k == 1);
      st.halt_state <= (k == 2);
      st.idle_state <= (k == 3);
      fc = 0;
      @(posedge mclk_i);
      bus(1'b1, OFF_ENGINE, 32'h80000000);
      bus(1'b0, OFF_ENGINE, '0);
      chk("force end", 32'(k == 0), 32'(fc));
      chk("flags", {8'h0, k == 2, 23'h0}, rv);
    end
    st <= '{thread_busy: 1'b1, default: 1'b0};
    @(posedge mclk_i);
    bus(1'b1, OFF_ENGINE, 32'h40000000);
    bus(1'b0, 16'h0800, '0);
    chk("channel error", 32'h1, {31'h0, ev});
    bus(1'b1, OFF_TB_ONE, '0);
    chk("time base write", 32'h1, {31'h0, ev});
    bus(1'b0, ram_a(12'h000), '0);
    chk("ram in stop", 32'h0, {31'h0, ev});
    #1;
    chk("thread finishes", 32'h1, {31'h0, run});
    @(posedge mclk_i);
    st.thread_busy <= 1'b0;
    @(posedge mclk_i);
    #1;
    chk("stop next edge", 32'h0, {31'h0, run});
    @(posedge mclk_i);
    bus(1'b0, OFF_TB_ONE, '0);
    chk("frozen time base", {8'h0, t1}, rv);
    bus(1'b0, OFF_ENGINE, '0);
    chk("stopped flag", 32'h50000000, rv);
    st.bus_stop <= 1'b1;
    st.peer_stopped <= 1'b1;
    @(posedge mclk_i);
    #1;
    chk("stop ack", 32'h1, {31'h0, ack});
    @(posedge mclk_i);
    st <= '{code_vis: 1'b1, default: 1'b0};
    @(posedge mclk_i);
    bus(1'b1, OFF_ENGINE, '0);
    bus(1'b0, OFF_ENGINE, '0);
    chk("stop locked", 32'h50000000, rv);
    st.code_vis <= 1'b0;
    @(posedge mclk_i);
    bus(1'b1, OFF_ENGINE, '0);
    bus(1'b0, OFF_ENGINE, '0);
    chk("stop released", 32'h0, {31'h0, rv[EC_STOP]});
    conclude();
  end
endmodule : coprocessor_host_config_tb
`default_nettype wire

// ==== dv/cphc_assertions.sv ====
// checker: bus timing, stop and entry address relations of the host config block
`timescale 1ns/10ps
`default_nettype none
module cphc_checker #(
  parameter int NCH = 32
) (
  // clock, reset and bus
  input wire logic                     mclk_i,
  input wire logic                     rst_i,
  input wire cphc_pkg::ahb_req_t       ahb_i,
  input wire cphc_pkg::ahb_rsp_t       ahb_o,
  // engine side
  input wire cphc_pkg::eng_ram_req_t   eng_ram_i,
  input wire logic                     eng_gnt_o,
  input wire logic [31:0]              eng_rdata_o,
  input wire cphc_pkg::engine_status_t eng_i,
  input wire logic                     force_end_o,
  input wire logic                     clk_run_o,
  input wire logic                     bus_stop_ack_o,
  input wire logic [15:0]              entry_host_addr_o,
  input wire logic [13:0]              entry_word_addr_o,
  input wire logic [23:0]              time_base_one_i,
  input wire logic [23:0]              time_base_two_i,
  // signature and channels
  input wire logic [31:0]              sig_calc_i,
  input wire logic                     sig_done_i,
  input wire logic                     sig_mismatch_o,
  input wire logic [NCH-1:0]           chan_pin_i,
  input wire logic [NCH-1:0]           chan_state_o
);
  import cphc_pkg::*;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic coh_q;
  // marks the first data-phase cycle of a write to the coherent register
  always_ff @(posedge mclk_i) begin
    if (rst_i) coh_q <= 1'b0;
    else coh_q <= ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready && ahb_i.hwrite
                  && ahb_i.haddr == OFF_COHERENT;
  end
  sequence s_start_seen;
    coh_q && ahb_i.hwdata[CT_START];
  endsequence
  sequence s_two_waits;
    !ahb_o.hreadyout ##1 !ahb_o.hreadyout ##1 ahb_o.hreadyout;
  endsequence
  a_coherent_wait: assert property (s_start_seen |-> s_two_waits)
    else $error("coherent start wait states wrong");
  a_no_start: assert property (coh_q && !ahb_i.hwdata[CT_START] |-> ahb_o.hreadyout)
    else $error("coherent write without start stalled");
  a_engine_locked: assert property (s_start_seen |-> ##1 !eng_gnt_o [*2])
    else $error("engine granted during coherent pair");
  a_force_thread_end_pulse: assert property (force_end_o |-> !ahb_o.hreadyout ##1 !force_end_o)
    else $error("force end pulse or wait wrong");
  a_error_two: assert property (ahb_o.hresp && !ahb_o.hreadyout |=> ahb_o.hresp && ahb_o.hreadyout)
    else $error("error response not two cycles");
  a_stop_thread: assert property ($fell(clk_run_o) |-> $past(!eng_i.thread_busy))
    else $error("engine stopped during a thread");
  a_stop_ack: assert property (bus_stop_ack_o |-> eng_i.bus_stop && eng_i.peer_stopped)
    else $error("stop acknowledged without both engines");
  a_sig_cause: assert property (sig_mismatch_o |-> $past(sig_done_i))
    else $error("mismatch without end of signature cycle");
  a_entry_pair: assert property (entry_host_addr_o == {entry_word_addr_o, 2'b00}
                                 && entry_host_addr_o[10:0] == 11'h000)
    else $error("entry table addresses disagree");
endmodule : cphc_checker
bind coprocessor_host_config cphc_checker #(.NCH(NCH)) chk_u (
  .mclk_i, .rst_i, .ahb_i, .ahb_o, .eng_ram_i, .eng_gnt_o, .eng_rdata_o, .eng_i,
  .force_end_o, .clk_run_o, .bus_stop_ack_o, .entry_host_addr_o, .entry_word_addr_o,
  .time_base_one_i, .time_base_two_i, .sig_calc_i, .sig_done_i, .sig_mismatch_o,
  .chan_pin_i, .chan_state_o);
`default_nettype wire

// ==== dv/cphc_engine_model.sv ====
// engine-side model: running time bases and a parameter ram reader
`timescale 1ns/10ps
`default_nettype none
module cphc_engine_model (
  // clock, reset and engine control
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  input  wire logic                  clk_run_i,
  // parameter ram reader
  input  wire logic                  gnt_i,
  input  wire logic [11:0]           rd_addr_i,
  output var  cphc_pkg::eng_ram_req_t ram_o,
  // time base values
  output logic [23:0]                tb1_o,
  output logic [23:0]                tb2_o
);
  import cphc_pkg::*;
  // time bases count only while clocks run; reader holds its request until granted
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tb1_o <= 24'h000000;
      tb2_o <= 24'h000000;
      ram_o <= '0;
    end else begin
      if (clk_run_i) begin
        tb1_o <= tb1_o + 24'h000001;
        tb2_o <= tb2_o + 24'h000003;
      end
      ram_o.req <= 1'b1;
      ram_o.wdata <= ~ram_o.wdata;  // unused on reads, never steady
      if (gnt_i || !ram_o.req) ram_o.addr <= rd_addr_i;
    end
  end
endmodule : cphc_engine_model
`default_nettype wire
